// ---- hw/eep_pkg.sv ----
package eep_pkg;
    // ------------------------------------------------------------
    // bus widths and clock
    // ------------------------------------------------------------
    localparam int ADDR_W = 16; // byte address pins
    localparam int DATA_W = 8; // byte-wide data pins
    localparam int CNT_W = 8; // short phase counter
    localparam int LONG_W = 24; // long delay counters
    localparam int CLK_NS = 8; // 125 mhz clock period

    // ------------------------------------------------------------
    // times in their own units
    // ------------------------------------------------------------
    localparam int RD_ACC_NS = 250; // slowest access grade, safe for all
    localparam int HZ_NS = 50; // ce/oe high to data released
    localparam int OES_NS = 10; // oe high before write strobe
    localparam int WP_NS = 100; // write strobe low width
    localparam int WPH_NS = 100; // strobe high recovery, covers addr hold
    localparam int DW_US = 10; // delay from write end to next write
    localparam int BLC_MAX_US = 100; // byte_load_window, longest gap
    localparam int PUR_US = 100; // powerup_read_delay
    localparam int PUW_MS = 5; // powerup_write_delay
    localparam int WRITE_MS = 10; // internal_write_time, plain default
    localparam int SYNC_CYC = 2; // data pin synchroniser depth

    // ------------------------------------------------------------
    // derived cycle counts (all round up except the byte load window, which rounds down)
    // ------------------------------------------------------------
    localparam int RD_CYC = (RD_ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC;
    localparam int HZ_CYC = (HZ_NS + CLK_NS - 1) / CLK_NS;
    localparam int OES_CYC = (OES_NS + CLK_NS - 1) / CLK_NS;
    localparam int WP_CYC = (WP_NS + CLK_NS - 1) / CLK_NS;
    localparam int WPH_CYC = (WPH_NS + CLK_NS - 1) / CLK_NS;
    localparam int DW_CYC = (DW_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int BLC_MAX_CYC = (BLC_MAX_US * 1000) / CLK_NS;
    localparam int PUR_CYC = (PUR_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int PUW_CYC = (PUW_MS * 1000000 + CLK_NS - 1) / CLK_NS;
    localparam int WRITE_CYC = (WRITE_MS * 1000000 + CLK_NS - 1) / CLK_NS;

    // last value of the phase counter in each timed state (poll shares the read one)
    localparam logic [CNT_W-1:0] RD_LAST = CNT_W'(RD_CYC - 1);
    localparam logic [CNT_W-1:0] HZ_LAST = CNT_W'(HZ_CYC - 1);
    localparam logic [CNT_W-1:0] OES_LAST = CNT_W'(OES_CYC - 1);
    localparam logic [CNT_W-1:0] WP_LAST = CNT_W'(WP_CYC - 1);
    localparam logic [CNT_W-1:0] WPH_LAST = CNT_W'(WPH_CYC - 1);

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic write; // 1 byte load, 0 read
        logic last; // final byte of a page
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } eep_req_t;

    typedef enum logic [2:0] {
        EEP_IDLE = 3'h0,
        EEP_RD = 3'h1,
        EEP_REC = 3'h3,
        EEP_WSET = 3'h2,
        EEP_WPULSE = 3'h6,
        EEP_WREC = 3'h7,
        EEP_PGAP = 3'h5,
        EEP_POLL = 3'h4
    } eep_state_t;
endpackage

// ---- hw/eep_host.sv ----
`timescale 1ns/1ps
module eep_host #(
    parameter int unsigned PUR_CYC = eep_pkg::PUR_CYC,
    parameter int unsigned PUW_CYC = eep_pkg::PUW_CYC,
    parameter int unsigned WRITE_CYC = eep_pkg::WRITE_CYC,
    parameter int unsigned GAP_CYC = eep_pkg::BLC_MAX_CYC,
    parameter int unsigned DW_CYC = eep_pkg::DW_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire eep_pkg::eep_req_t req,
    input wire logic req_valid,
    output logic req_ready_q,
    output logic rsp_valid_q,
    output logic [eep_pkg::DATA_W-1:0] rsp_data_q,
    output logic wdone_q,
    output logic werr_q,
    output logic ce_n_q,
    output logic oe_n_q,
    output logic we_n_q,
    output logic [eep_pkg::ADDR_W-1:0] addr_q,
    output logic [eep_pkg::DATA_W-1:0] dq_o_q,
    output logic dq_oe_n_q,
    input wire logic [eep_pkg::DATA_W-1:0] dq_i
);
    // ------------------------------------------------------------
    // state and counters
    // ------------------------------------------------------------
    eep_pkg::eep_state_t st_q, st_d; // sequencer state
    logic [eep_pkg::CNT_W-1:0] cnt_q, cnt_d; // phase counter
    logic [eep_pkg::LONG_W-1:0] pu_q, pu_d; // time since reset, saturating
    logic [eep_pkg::LONG_W-1:0] lt_q, lt_d; // gap or write timer
    logic [eep_pkg::LONG_W-1:0] dw_q, dw_d; // hold-off before next write
    logic pbit_q, pbit_d; // bit 7 of the last byte loaded
    logic last_q, last_d; // current load closes the page
    logic poll_q, poll_d; // recovery leads back into polling
    logic ready_d, rsp_valid_d, wdone_d, werr_d;
    logic [eep_pkg::DATA_W-1:0] rsp_data_d, dq_o_d;
    logic [eep_pkg::ADDR_W-1:0] addr_d;
    logic ce_n_d, oe_n_d, we_n_d, dq_oe_n_d;
    logic [eep_pkg::DATA_W-1:0] dq_meta_q, dq_sync_q; // pin synchroniser

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire pur_ok = pu_q >= eep_pkg::LONG_W'(PUR_CYC);
    wire puw_ok = pu_q >= eep_pkg::LONG_W'(PUW_CYC);
    wire dw_ok = dw_q == 24'h00_0000;
    // reads wait for the short delay, writes for the long one
    wire idle_take = (st_q == eep_pkg::EEP_IDLE) &&
                     (!req.write || (puw_ok && dw_ok));
    // inside a page only further byte loads are taken
    wire gap_take = (st_q == eep_pkg::EEP_PGAP) && req.write;
    wire take = req_valid && req_ready_q && (idle_take || gap_take);
    wire gap_over = lt_q >= eep_pkg::LONG_W'(GAP_CYC - eep_pkg::OES_CYC -
                                              eep_pkg::WP_CYC);
    wire wt_over = lt_q >= eep_pkg::LONG_W'(WRITE_CYC);
    wire poll_hit = dq_sync_q[eep_pkg::DATA_W-1] == pbit_q;
    assign pu_d = puw_ok ? pu_q : pu_q + 24'h00_0001;

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    // pins are only ever moved one step per state so that no mode
    // between read and write is crossed by accident
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q + 8'h01;
        lt_d = lt_q;
        dw_d = dw_ok ? dw_q : dw_q - 24'h00_0001;
        pbit_d = pbit_q;
        last_d = last_q;
        poll_d = poll_q;
        rsp_valid_d = 1'b0;
        rsp_data_d = rsp_data_q;
        wdone_d = 1'b0;
        werr_d = 1'b0;
        addr_d = addr_q;
        dq_o_d = dq_o_q;
        ce_n_d = ce_n_q;
        oe_n_d = oe_n_q;
        we_n_d = we_n_q;
        dq_oe_n_d = dq_oe_n_q;
        case (st_q)
            eep_pkg::EEP_IDLE, eep_pkg::EEP_PGAP: begin
                // page gap: ce, oe and we all high keeps the page open
                if (st_q == eep_pkg::EEP_PGAP) begin
                    lt_d = lt_q + 24'h00_0001;
                end
                if (take) begin
                    addr_d = req.addr;
                    cnt_d = 8'h00;
                    ce_n_d = 1'b0;
                    if (req.write) begin
                        // write mode: ce low, oe high, data driven
                        dq_o_d = req.data;
                        pbit_d = req.data[eep_pkg::DATA_W-1];
                        last_d = req.last;
                        dq_oe_n_d = 1'b0;
                        st_d = eep_pkg::EEP_WSET;
                    end else begin
                        oe_n_d = 1'b0;
                        st_d = eep_pkg::EEP_RD;
                    end
                end else if (st_q == eep_pkg::EEP_PGAP && gap_over) begin
                    // window closed by silence: the device starts writing
                    lt_d = 24'h00_0000;
                    poll_d = 1'b1;
                    cnt_d = 8'h00;
                    st_d = eep_pkg::EEP_REC;
                end
            end
            eep_pkg::EEP_RD: begin
                if (cnt_q == eep_pkg::RD_LAST) begin
                    rsp_data_d = dq_sync_q;
                    rsp_valid_d = 1'b1;
                    ce_n_d = 1'b1;
                    oe_n_d = 1'b1;
                    cnt_d = 8'h00;
                    poll_d = 1'b0;
                    st_d = eep_pkg::EEP_REC;
                end
            end
            eep_pkg::EEP_REC: begin
                // bus turnaround while the device releases the data pins
                if (poll_q) begin
                    lt_d = lt_q + 24'h00_0001;
                end
                if (cnt_q == eep_pkg::HZ_LAST) begin
                    cnt_d = 8'h00;
                    if (poll_q) begin
                        ce_n_d = 1'b0;
                        oe_n_d = 1'b0;
                        st_d = eep_pkg::EEP_POLL;
                    end else begin
                        st_d = eep_pkg::EEP_IDLE;
                    end
                end
            end
            eep_pkg::EEP_WSET: begin
                // oe high setup before the strobe falls
                if (cnt_q == eep_pkg::OES_LAST) begin
                    we_n_d = 1'b0;
                    cnt_d = 8'h00;
                    st_d = eep_pkg::EEP_WPULSE;
                end
            end
            eep_pkg::EEP_WPULSE: begin
                if (cnt_q == eep_pkg::WP_LAST) begin
                    we_n_d = 1'b1;
                    cnt_d = 8'h00;
                    st_d = eep_pkg::EEP_WREC;
                end
            end
            eep_pkg::EEP_WREC: begin
                // address and data held through strobe recovery
                if (cnt_q == eep_pkg::WPH_LAST) begin
                    ce_n_d = 1'b1;
                    dq_oe_n_d = 1'b1;
                    cnt_d = 8'h00;
                    lt_d = 24'h00_0000;
                    poll_d = 1'b1;
                    st_d = last_q ? eep_pkg::EEP_REC : eep_pkg::EEP_PGAP;
                end
            end
            eep_pkg::EEP_POLL: begin
                // status poll is a plain read at the last load address
                lt_d = lt_q + 24'h00_0001;
                if (cnt_q == eep_pkg::RD_LAST) begin
                    ce_n_d = 1'b1;
                    oe_n_d = 1'b1;
                    cnt_d = 8'h00;
                    st_d = eep_pkg::EEP_REC;
                    // no other access until the write is seen complete or the write timer runs out
                    if (poll_hit || wt_over) begin
                        wdone_d = 1'b1;
                        werr_d = !poll_hit;
                        poll_d = 1'b0;
                        dw_d = eep_pkg::LONG_W'(DW_CYC);
                    end
                end
            end
            default: begin
                st_d = eep_pkg::EEP_IDLE;
            end
        endcase
        ready_d = (st_d == eep_pkg::EEP_IDLE && pur_ok) ||
                  st_d == eep_pkg::EEP_PGAP;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // data pins cross from outside: two stages before any reader
    always_ff @(posedge clk) begin
        dq_meta_q <= dq_i;
        dq_sync_q <= dq_meta_q;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_q <= eep_pkg::EEP_IDLE;
            cnt_q <= 8'h00;
            pu_q <= 24'h00_0000;
            lt_q <= 24'h00_0000;
            dw_q <= 24'h00_0000;
            pbit_q <= 1'b0;
            last_q <= 1'b0;
            poll_q <= 1'b0;
            req_ready_q <= 1'b0;
            rsp_valid_q <= 1'b0;
            rsp_data_q <= 8'h00;
            wdone_q <= 1'b0;
            werr_q <= 1'b0;
            addr_q <= 16'h0000;
            dq_o_q <= 8'h00;
            // deselected: standby and write inhibit from reset on
            ce_n_q <= 1'b1;
            oe_n_q <= 1'b1;
            we_n_q <= 1'b1;
            dq_oe_n_q <= 1'b1;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            pu_q <= pu_d;
            lt_q <= lt_d;
            dw_q <= dw_d;
            pbit_q <= pbit_d;
            last_q <= last_d;
            poll_q <= poll_d;
            req_ready_q <= ready_d;
            rsp_valid_q <= rsp_valid_d;
            rsp_data_q <= rsp_data_d;
            wdone_q <= wdone_d;
            werr_q <= werr_d;
            addr_q <= addr_d;
            dq_o_q <= dq_o_d;
            ce_n_q <= ce_n_d;
            oe_n_q <= oe_n_d;
            we_n_q <= we_n_d;
            dq_oe_n_q <= dq_oe_n_d;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    logic [eep_pkg::CNT_W-1:0] we_lo_q, oe_lo_q; // strobe low widths
    always_ff @(posedge clk) begin
        we_lo_q <= we_n_q ? 8'h00 : we_lo_q + 8'h01;
        oe_lo_q <= oe_n_q ? 8'h00 : oe_lo_q + 8'h01;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_pu_read;
        $fell(oe_n_q) |-> pu_q >= eep_pkg::LONG_W'(PUR_CYC);
    endproperty
    a_pu_read: assert property (p_pu_read)
        else $error("read issued before powerup read delay");
    property p_pu_write;
        !we_n_q |-> pu_q >= eep_pkg::LONG_W'(PUW_CYC);
    endproperty
    a_pu_write: assert property (p_pu_write)
        else $error("write issued before powerup write delay");
    property p_we_width;
        $rose(we_n_q) |-> we_lo_q >= eep_pkg::CNT_W'(eep_pkg::WP_CYC);
    endproperty
    a_we_width: assert property (p_we_width)
        else $error("write strobe too short");
    property p_we_mode;
        !we_n_q |-> oe_n_q && !ce_n_q && !dq_oe_n_q;
    endproperty
    a_we_mode: assert property (p_we_mode)
        else $error("write strobe outside write mode");
    property p_oe_width;
        $rose(oe_n_q) |-> oe_lo_q == eep_pkg::CNT_W'(eep_pkg::RD_CYC);
    endproperty
    a_oe_width: assert property (p_oe_width)
        else $error("read or poll not of read cycle length");
    sequence s_done_ok;
        wdone_q && !werr_q;
    endsequence
    property p_done_cause;
        s_done_ok |-> $past(dq_sync_q[eep_pkg::DATA_W-1]) == pbit_q;
    endproperty
    a_done_cause: assert property (p_done_cause)
        else $error("write reported done without matching poll");
    property p_poll_mode;
        !oe_n_q |-> !ce_n_q && we_n_q && dq_oe_n_q;
    endproperty
    a_poll_mode: assert property (p_poll_mode)
        else $error("read or poll with bad pin levels");
    property p_gap_quiet;
        st_q == eep_pkg::EEP_PGAP |-> ce_n_q && we_n_q && oe_n_q;
    endproperty
    a_gap_quiet: assert property (p_gap_quiet)
        else $error("page gap disturbed by another access");
endmodule

// ---- hw/eep_host_unused_placeholder_none.sv ----
`timescale 1ns/1ps

// ---- bench/eep_dev_model.sv ----
`timescale 1ns/1ps
// device side: mode decode, page buffer, self-timed write
module eep_dev_model #(
    parameter int WT_CYC = 200, // internal_write_time in sim cycles
    parameter int BLC_CYC = 100 // byte_load_window in sim cycles
) (
    input wire logic clk,
    input wire logic slow, // long access time when high
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [15:0] addr,
    input wire logic [7:0] din,
    output logic [7:0] dout,
    output logic dout_en
);
    logic [7:0] mem [0:65535]; // array contents
    logic [15:0] pa [$]; // page addresses awaiting commit
    logic [7:0] pd [$]; // page data awaiting commit
    logic [15:0] a_q = '0;
    logic [7:0] d_q = '0;
    logic [7:0] last_b = '0; // last loaded byte, for polling
    logic wr_q = 1'b0;
    logic busy = 1'b0; // page open or internal write running
    int tmr = 0; // cycles since the last load
    int acc = 0; // cycles since read mode began
    wire rd_sel = !ce_n && !oe_n && we_n;
    wire wr_sel = !ce_n && !we_n && oe_n;
    // while busy a read is a status poll: bit 7 inverted
    wire [7:0] val = busy ? {~last_b[7], acc[6:0]} : mem[addr];
    // data not yet valid shows the inverse, never a stale copy
    assign dout = (acc >= (slow ? 30 : 2)) ? val : ~val;
    assign dout_en = rd_sel;
    // a load lands when the strobe ends; oe pulses leave the page open
    always @(posedge clk) begin
        acc <= rd_sel ? acc + 1 : 0;
        wr_q <= wr_sel;
        if (wr_sel) begin
            a_q <= addr;
            d_q <= din;
        end
        if (wr_q && !wr_sel && (!busy || tmr < BLC_CYC)) begin
            pa.push_back(a_q);
            pd.push_back(d_q);
            last_b <= d_q;
            busy <= 1'b1;
            tmr <= 0;
        end else if (busy) begin
            tmr <= tmr + 1;
            if (tmr == WT_CYC) begin
                foreach (pa[i]) mem[pa[i]] <= pd[i];
                pa.delete();
                pd.delete();
                busy <= 1'b0;
            end
        end
    end
endmodule

// ---- bench/eep_host_tb.sv ----
`timescale 1ns/1ps
`define CHK(a, b, m) begin num_checks++; if ((a) !== (b)) begin \
    errors++; $display("BAD %0t %s", $time, m); end end
module eep_host_tb;
    localparam int PUR = 20; // shortened powerup_read_delay
    localparam int PUW = 40; // shortened powerup_write_delay
    localparam int RDMIN = eep_pkg::RD_ACC_NS / eep_pkg::CLK_NS;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    eep_pkg::eep_req_t req = '0;
    logic req_valid = 1'b0;
    logic slow = 1'b1; // device answers slowly when high
    logic req_ready_q, rsp_valid_q, wdone_q, werr_q, dev_en;
    logic ce_n_q, oe_n_q, we_n_q, dq_oe_n_q;
    logic [7:0] rsp_data_q, dq_o_q, dev_dq;
    logic [7:0] dq_last = '0;
    logic [15:0] addr_q;
    wire [7:0] dq_i;
    int errors = 0;
    int num_checks = 0;
    int cyc = 0;
    int c0 = 0;
    int rc = 0;
    int wc = 0;
    initial forever #4 clk = ~clk;
    eep_host #(.PUR_CYC(PUR), .PUW_CYC(PUW), .WRITE_CYC(400),
        .GAP_CYC(80), .DW_CYC(10)) uut (.clk(clk), .rstn(rstn),
        .req(req), .req_valid(req_valid), .req_ready_q(req_ready_q),
        .rsp_valid_q(rsp_valid_q), .rsp_data_q(rsp_data_q),
        .wdone_q(wdone_q), .werr_q(werr_q), .ce_n_q(ce_n_q),
        .oe_n_q(oe_n_q), .we_n_q(we_n_q), .addr_q(addr_q),
        .dq_o_q(dq_o_q), .dq_oe_n_q(dq_oe_n_q), .dq_i(dq_i));
    eep_dev_model dev (.clk(clk), .slow(slow), .ce_n(ce_n_q),
        .oe_n(oe_n_q), .we_n(we_n_q), .addr(addr_q), .din(dq_i),
        .dout(dev_dq), .dout_en(dev_en));
    // undriven bus floats to the inverse of its last level
    assign dq_i = !dq_oe_n_q ? dq_o_q : (dev_en ? dev_dq : ~dq_last);
    // cycle count, bus history and hang limit
    always @(posedge clk) begin
        cyc <= cyc + 1;
        dq_last <= dq_i;
        if (cyc == 20000) begin
            errors++;
            $display("BAD %0t hang limit", $time);
            report_and_stop();
        end
    end
    // pin watcher: bus fights, read and strobe widths
    always @(posedge clk) begin
        if (rstn) begin
            if (dev_en) `CHK(dq_oe_n_q, 1'b1, "bus fight")
            if (!ce_n_q && !oe_n_q) rc++;
            else if (rc != 0) begin
                `CHK(rc >= RDMIN, 1'b1, "short read")
                rc = 0;
            end
            if (!we_n_q) begin
                wc++;
                `CHK({ce_n_q, oe_n_q}, 2'b01, "bad strobe")
            end else if (wc != 0) begin
                `CHK(wc >= eep_pkg::WP_CYC, 1'b1, "short we")
                wc = 0;
            end
        end
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // hold a request until ready is seen to fall after being high
    task automatic send(input eep_pkg::eep_req_t r, output int t);
        int n;
        n = 0;
        @(posedge clk);
        req <= r;
        req_valid <= 1'b1;
        #1;
        while (req_ready_q !== 1'b1 && n < 5000) begin
            @(posedge clk);
            #1;
            n++;
        end
        while (req_ready_q !== 1'b0 && n < 5000) begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHK(n < 5000, 1'b1, "request never taken")
        t = cyc;
        @(posedge clk);
        req_valid <= 1'b0;
    endtask
    task automatic wait_out(input logic rd);
        int n;
        n = 0;
        while ((rd ? rsp_valid_q : wdone_q) !== 1'b1 && n < 3000) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (rd) `CHK(n < 3000, 1'b1, "no read answer")
        else `CHK(n < 3000, 1'b1, "no write done")
        if (!rd) `CHK(dev.busy, 1'b0, "done while busy")
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d,
        input logic l);
        int t;
        send('{write: 1'b1, last: l, addr: a, data: d}, t);
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] d);
        int t;
        send('{write: 1'b0, last: 1'b0, addr: a, data: 8'h00}, t);
        wait_out(1'b1);
        `CHK(rsp_data_q, d, "read data")
    endtask
    task automatic t_power();
        int t;
        repeat (PUR / 2) @(posedge clk);
        #1;
        `CHK(req_ready_q, 1'b0, "ready early")
        send('{write: 1'b1, last: 1'b1, addr: 16'h0010, data: 8'ha5}, t);
        `CHK(t - c0 >= PUW - 1, 1'b1, "write early")
        wait_out(1'b0);
        `CHK(werr_q, 1'b0, "write timer ran out")
        $display("power-up test done");
    endtask
    task automatic t_read();
        @(posedge clk);
        slow <= 1'b0;
        rd_chk(16'h0010, 8'ha5);
        slow <= 1'b1;
        rd_chk(16'h0010, 8'ha5);
        $display("read test done");
    endtask
    task automatic t_page();
        wr(16'h0100, 8'h3c, 1'b0);
        wr(16'h0101, 8'hc3, 1'b0);
        wr(16'h0102, 8'h81, 1'b1);
        wait_out(1'b0);
        `CHK(werr_q, 1'b0, "page poll failed")
        rd_chk(16'h0100, 8'h3c);
        rd_chk(16'h0101, 8'hc3);
        rd_chk(16'h0102, 8'h81);
        $display("page test done");
    endtask
    // a read held in the page gap waits for the page to close
    task automatic t_gap();
        int bad;
        int n;
        bad = 0;
        n = 0;
        wr(16'h0200, 8'h7e, 1'b0);
        while (req_ready_q !== 1'b1 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        @(posedge clk);
        req <= '{write: 1'b0, last: 1'b0, addr: 16'h0200, data: 8'h00};
        req_valid <= 1'b1;
        repeat (30) begin
            @(posedge clk);
            #1;
            if (ce_n_q !== 1'b1 || req_ready_q !== 1'b1) bad++;
        end
        `CHK(bad, 0, "read entered page gap")
        wait_out(1'b0);
        `CHK(werr_q, 1'b0, "closed page not done")
        wait_out(1'b1);
        `CHK(rsp_data_q, 8'h7e, "closed page data")
        @(posedge clk);
        req_valid <= 1'b0;
        $display("gap test done");
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        #1;
        c0 = cyc;
        t_power();
        t_read();
        t_page();
        t_gap();
        report_and_stop();
    end
endmodule
